// File: psaddr_core.sv
`timescale 1ns/1ps
`include "psaddr_regs.svh"
// =============================================
// Notes on behaviour
// - Hardware updates carry, aux, overflow, negative, zero
// - Parity tracks accumulator; status writes skip it
// - Bank bits select bank for registers 0-7
// - All banks visible as memory bytes 00h-1Fh
// - Two spare flags only software changes
// - Shared bits are one storage in both
// - Multiply and divide clear carry
// - Zero divisor sets overflow flag
// - Aux carry changes only on byte ops
// - Shifts load carry with bit shifted out
// - External region byte resets to 01h
// - Dword immediate fills upper word zeros/ones
// - Dword move writes high, or low extended
// - Increment/decrement step is 1, 2 or 4
// - Dir8 reaches low RAM; SFR bytes only
// - Dir16 reaches region zero bytes and words
// - Indirect arithmetic source is byte, dest register
// - Word indirect addresses region zero
// - Dword indirect uses low 24 bits
// - Byte-register indirect reaches 00h-FFh
// - Word displacement wraps within region zero
// - Dword displacement adds signed 16-bit offset
module psaddr_core
  import psaddr_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  // Status and addressing observation
  output logic      [1:0]  active_bank,
  output logic      [23:0] operand_addr
);

  // ==========================================
  // Bus decode
  logic setup_ph;
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  assign setup_ph = psel && !penable;
  assign wr_acc   = psel && penable && pready && pwrite;
  assign rd_acc   = psel && penable && pready && !pwrite;

  always_comb begin
    unique case (paddr)
      `PSADDR_OFF_PSW, `PSADDR_OFF_EXTENDED_STATUS_REGISTER, `PSADDR_OFF_ACC, `PSADDR_OFF_OPCTL,
      `PSADDR_OFF_OPA, `PSADDR_OFF_OPB, `PSADDR_OFF_RESULT, `PSADDR_OFF_AGCTL,
      `PSADDR_OFF_AGBASE, `PSADDR_OFF_AGOFS, `PSADDR_OFF_AGOUT, `PSADDR_OFF_DPX,
      `PSADDR_OFF_REGIDX, `PSADDR_OFF_REGDATA, `PSADDR_OFF_RAMADDR,
      `PSADDR_OFF_RAMDATA: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Ready one cycle into the access phase, after RAM read settles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  // ==========================================
  // Status storage, one bit each
  logic cy, ac, ov, rs0, rs1, f0, ud, nf, zf, par;
  logic [7:0]  acc;
  psaddr_opctl_t opctl;
  logic [31:0] opa, opb, result;
  logic        op_go;
  logic        opctl_pend;
  logic [7:0]  psw_view, extended_status_register_view;

  assign psw_view  = {cy, ac, f0, rs1, rs0, ov, ud, par};
  assign extended_status_register_view = {cy, ac, nf, rs1, rs0, ov, zf, 1'b0};

  // ==========================================
  // Datapath
  logic [32:0] sum;
  logic [31:0] next_result;
  logic        next_cy, next_ac, next_ov, next_n, next_z;
  logic        upd_cy, upd_ac, upd_ov;
  logic [31:0] step_val;
  logic [31:0] mask;
  logic        msb_a, msb_b, msb_r;
  int unsigned top;

  always_comb begin
    unique case (opctl.size)
      PSADDR_SZ_BYTE:  begin mask = 32'h000000FF; top = 7;  end
      PSADDR_SZ_WORD:  begin mask = 32'h0000FFFF; top = 15; end
      default:         begin mask = 32'hFFFFFFFF; top = 31; end
    endcase
  end

  always_comb begin
    unique case (opctl.step)
      2'h0:    step_val = 32'h00000001;
      2'h1:    step_val = 32'h00000002;
      default: step_val = 32'h00000004;
    endcase
  end

  always_comb begin
    sum         = 33'h000000000;
    next_result = result;
    next_cy     = cy;
    next_ac     = ac;
    next_ov     = ov;
    upd_cy      = 1'b0;
    upd_ac      = 1'b0;
    upd_ov      = 1'b0;
    unique case (opctl.op)
      PSADDR_OP_ADD, PSADDR_OP_INC: begin
        sum = {1'b0, opa & mask} +
              {1'b0, (opctl.op == PSADDR_OP_INC) ? step_val : (opb & mask)};
        next_result = sum[31:0] & mask;
        next_cy = sum[top + 1];
        next_ac = sum[4] ^ opa[4] ^ opb[4];
        upd_cy = 1'b1;
        upd_ac = 1'b1;
        upd_ov = 1'b1;
      end
      PSADDR_OP_SUB, PSADDR_OP_CMP, PSADDR_OP_DEC: begin
        sum = {1'b0, opa & mask} -
              {1'b0, (opctl.op == PSADDR_OP_DEC) ? step_val : (opb & mask)};
        if (opctl.op != PSADDR_OP_CMP) begin
          next_result = sum[31:0] & mask;
        end
        next_cy = sum[top + 1];
        next_ac = sum[4] ^ opa[4] ^ opb[4];
        upd_cy = 1'b1;
        upd_ac = 1'b1;
        upd_ov = 1'b1;
      end
      PSADDR_OP_MUL: begin
        next_result = (opctl.size == PSADDR_SZ_BYTE) ?
                      {16'h0000, 16'(opa[7:0]) * 16'(opb[7:0])}
                      : 32'(opa[15:0]) * 32'(opb[15:0]);
        next_cy = 1'b0;
        upd_cy = 1'b1;
        next_ov = (opctl.size == PSADDR_SZ_BYTE) ? (next_result[15:8] != 8'h00)
                                                 : (next_result[31:16] != 16'h0000);
        upd_ov = 1'b1;
      end
      PSADDR_OP_DIV: begin
        next_cy = 1'b0;
        upd_cy = 1'b1;
        upd_ov = 1'b1;
        if ((opctl.size == PSADDR_SZ_BYTE && opb[7:0] == 8'h00) ||
            (opctl.size != PSADDR_SZ_BYTE && opb[15:0] == 16'h0000)) begin
          next_ov = 1'b1;
        end else if (opctl.size == PSADDR_SZ_BYTE) begin
          next_ov = 1'b0;
          next_result = {16'h0000, opa[7:0] % opb[7:0], opa[7:0] / opb[7:0]};
        end else begin
          next_ov = 1'b0;
          next_result = {opa[15:0] % opb[15:0], opa[15:0] / opb[15:0]};
        end
      end
      PSADDR_OP_AND: next_result = opa & opb & mask;
      PSADDR_OP_OR:  next_result = (opa | opb) & mask;
      PSADDR_OP_XOR: next_result = (opa ^ opb) & mask;
      PSADDR_OP_SLL: begin
        next_result = (opa << 1) & mask;
        next_cy = opa[top];
        upd_cy = 1'b1;
      end
      PSADDR_OP_SRL, PSADDR_OP_SRA: begin
        next_result = (opa & mask) >> 1;
        if (opctl.op == PSADDR_OP_SRA) begin
          next_result[top] = opa[top];
        end
        next_cy = opa[0];
        upd_cy = 1'b1;
      end
      PSADDR_OP_MOVH: next_result = {opb[15:0], opa[15:0]};
      PSADDR_OP_MOVL: next_result = {opctl.fill_ones ? `PSADDR_WORD_ONES
                                    : `PSADDR_WORD_ZERO, opb[15:0]};
      PSADDR_OP_IMM: next_result = {opctl.fill_ones ? `PSADDR_WORD_ONES
                                   : `PSADDR_WORD_ZERO, opb[15:0]};
    endcase
    msb_a = opa[top];
    msb_b = opb[top];
    msb_r = sum[top];
    if (opctl.op == PSADDR_OP_ADD || opctl.op == PSADDR_OP_INC) begin
      next_ov = (msb_a == msb_b) && (msb_r != msb_a);
    end else if (opctl.op == PSADDR_OP_SUB || opctl.op == PSADDR_OP_CMP ||
                 opctl.op == PSADDR_OP_DEC) begin
      next_ov = (msb_a != msb_b) && (msb_r != msb_a);
    end
    if (opctl.size != PSADDR_SZ_BYTE) begin
      upd_ac = 1'b0;
    end
    next_n = (opctl.op == PSADDR_OP_CMP) ? sum[top] : next_result[top];
    next_z = (opctl.op == PSADDR_OP_CMP) ? ((sum[31:0] & mask) == 32'h00000000)
                                         : (next_result == 32'h00000000);
  end

  assign op_go = wr_acc && paddr == `PSADDR_OFF_OPCTL;

  // ==========================================
  // Status bits: one register per bit, two write paths
  logic wr_psw, wr_extended_status_register;
  assign wr_psw  = wr_acc && paddr == `PSADDR_OFF_PSW;
  assign wr_extended_status_register = wr_acc && paddr == `PSADDR_OFF_EXTENDED_STATUS_REGISTER;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {cy, ac, ov, rs0, rs1, f0, ud, nf, zf} <= 9'h000;
    end else if (wr_psw) begin
      cy  <= pwdata[`PSADDR_PSW_CY];
      ac  <= pwdata[`PSADDR_PSW_AC];
      f0  <= pwdata[`PSADDR_PSW_F0];
      rs1 <= pwdata[`PSADDR_PSW_RS1];
      rs0 <= pwdata[`PSADDR_PSW_RS0];
      ov  <= pwdata[`PSADDR_PSW_OV];
      ud  <= pwdata[`PSADDR_PSW_UD];
    end else if (wr_extended_status_register) begin
      cy  <= pwdata[`PSADDR_EXTENDED_STATUS_REGISTER_CY];
      ac  <= pwdata[`PSADDR_EXTENDED_STATUS_REGISTER_AC];
      nf  <= pwdata[`PSADDR_EXTENDED_STATUS_REGISTER_N];
      rs1 <= pwdata[`PSADDR_EXTENDED_STATUS_REGISTER_RS1];
      rs0 <= pwdata[`PSADDR_EXTENDED_STATUS_REGISTER_RS0];
      ov  <= pwdata[`PSADDR_EXTENDED_STATUS_REGISTER_OV];
      zf  <= pwdata[`PSADDR_EXTENDED_STATUS_REGISTER_Z];
    end else if (opctl_pend) begin
      if (upd_cy) cy <= next_cy;
      if (upd_ac) ac <= next_ac;
      if (upd_ov) ov <= next_ov;
      nf <= next_n;
      zf <= next_z;
    end
  end

  // Parity follows the accumulator only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= 8'h00;
      par <= 1'b0;
    end else begin
      if (wr_acc && paddr == `PSADDR_OFF_ACC) begin
        acc <= pwdata[7:0];
      end
      par <= ^acc;
    end
  end

  // ==========================================
  // Operation registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opctl  <= '0;
      opa    <= 32'h00000000;
      opb    <= 32'h00000000;
      result <= 32'h00000000;
    end else begin
      if (op_go) opctl <= psaddr_opctl_t'(pwdata[$bits(psaddr_opctl_t)-1:0]);
      if (wr_acc && paddr == `PSADDR_OFF_OPA) opa <= pwdata;
      if (wr_acc && paddr == `PSADDR_OFF_OPB) opb <= pwdata;
      if (opctl_pend) result <= next_result;
    end
  end

  // Result and flags latched one cycle after the control write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) opctl_pend <= 1'b0;
    else          opctl_pend <= op_go;
  end

  // ==========================================
  // Register file bytes with bank select
  logic [4:0]  reg_idx;
  logic [4:0]  reg_phys;
  logic [31:0] extended_pointer_dword;
  logic [4:0]  ram_addr;
  logic        ram_we;
  logic [4:0]  ram_waddr, ram_raddr;
  logic [7:0]  ram_wdata, ram_rdata;

  // Bank bits pick physical slot for bytes 0-7
  assign reg_phys = (reg_idx < 5'h08) ? {rs1, rs0, reg_idx[2:0]} : reg_idx;
  assign ram_we = wr_acc && (paddr == `PSADDR_OFF_REGDATA ||
                             paddr == `PSADDR_OFF_RAMDATA);
  assign ram_waddr = (paddr == `PSADDR_OFF_REGDATA) ? reg_phys : ram_addr;
  assign ram_raddr = (paddr == `PSADDR_OFF_REGDATA) ? reg_phys : ram_addr;
  assign ram_wdata = pwdata[7:0];

  psaddr_ram u_ram (
    .pclk  (pclk),
    .we    (ram_we),
    .waddr (ram_waddr),
    .wdata (ram_wdata),
    .raddr (ram_raddr),
    .rdata (ram_rdata)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_idx  <= 5'h00;
      ram_addr <= 5'h00;
      extended_pointer_dword      <= {24'h000000, `PSADDR_EXTERNAL_REGION_SELECT_RST};
    end else begin
      if (wr_acc && paddr == `PSADDR_OFF_REGIDX)  reg_idx  <= pwdata[4:0];
      if (wr_acc && paddr == `PSADDR_OFF_RAMADDR) ram_addr <= pwdata[4:0];
      if (wr_acc && paddr == `PSADDR_OFF_DPX)     extended_pointer_dword      <= pwdata;
    end
  end

  // ==========================================
  // Operand address generation
  psaddr_agctl_t agctl;
  logic [31:0]   agbase;
  logic [15:0]   agofs;
  psaddr_agout_t agout;
  psaddr_agout_t next_agout;

  always_comb begin
    next_agout = '0;
    unique case (agctl.mode)
      PSADDR_AM_DIR8: begin
        next_agout.addr = {8'h00, agofs & 16'h01FF};
        next_agout.sfr  = agctl.sfr;
        // SFRs bytes only; RAM limited to low window
        next_agout.fault = agctl.sfr ? (agctl.word_access ||
                                        next_agout.addr > `PSADDR_SFR_TOP)
                                     : (next_agout.addr > `PSADDR_LOW_RAM_TOP);
      end
      PSADDR_AM_DIR16:  next_agout.addr = {8'h00, agofs};
      PSADDR_AM_IND_W:  next_agout.addr = {8'h00, agbase[15:0]};
      PSADDR_AM_IND_D: begin
        next_agout.addr  = agbase[23:0];
        next_agout.fault = agbase[31:24] != 8'h00;
      end
      PSADDR_AM_IND_RI: next_agout.addr = {16'h0000, agbase[7:0]};
      PSADDR_AM_DISP_W: next_agout.addr = {8'h00, agbase[15:0] + agofs};
      PSADDR_AM_DISP_D: begin
        next_agout.addr  = agbase[23:0] + {{8{agofs[15]}}, agofs};
        next_agout.fault = agbase[31:24] != 8'h00;
      end
      PSADDR_AM_EXT: next_agout.addr = {extended_pointer_dword[7:0], agbase[15:0]};
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      agctl  <= '0;
      agbase <= 32'h00000000;
      agofs  <= 16'h0000;
      agout  <= '0;
    end else begin
      if (wr_acc && paddr == `PSADDR_OFF_AGCTL)
        agctl <= psaddr_agctl_t'(pwdata[$bits(psaddr_agctl_t)-1:0]);
      if (wr_acc && paddr == `PSADDR_OFF_AGBASE) agbase <= pwdata;
      if (wr_acc && paddr == `PSADDR_OFF_AGOFS)  agofs  <= pwdata[15:0];
      agout <= next_agout;
    end
  end

  // ==========================================
  // Read mux and outputs
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h00000000;
    unique case (paddr)
      `PSADDR_OFF_PSW:     next_prdata = {24'h000000, psw_view};
      `PSADDR_OFF_EXTENDED_STATUS_REGISTER:    next_prdata = {24'h000000, extended_status_register_view};
      `PSADDR_OFF_ACC:     next_prdata = {24'h000000, acc};
      `PSADDR_OFF_OPCTL:   next_prdata = {{(32-$bits(psaddr_opctl_t)){1'b0}}, opctl};
      `PSADDR_OFF_OPA:     next_prdata = opa;
      `PSADDR_OFF_OPB:     next_prdata = opb;
      `PSADDR_OFF_RESULT:  next_prdata = result;
      `PSADDR_OFF_AGCTL:   next_prdata = {{(32-$bits(psaddr_agctl_t)){1'b0}}, agctl};
      `PSADDR_OFF_AGBASE:  next_prdata = agbase;
      `PSADDR_OFF_AGOFS:   next_prdata = {16'h0000, agofs};
      `PSADDR_OFF_AGOUT:   next_prdata = {6'h00, agout};
      `PSADDR_OFF_DPX:     next_prdata = extended_pointer_dword;
      `PSADDR_OFF_REGIDX:  next_prdata = {27'h0000000, reg_idx};
      `PSADDR_OFF_RAMADDR: next_prdata = {27'h0000000, ram_addr};
      `PSADDR_OFF_REGDATA, `PSADDR_OFF_RAMDATA: next_prdata = {24'h000000, ram_rdata};
      default:             next_prdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata       <= 32'h00000000;
      pslverr      <= 1'b0;
      active_bank  <= 2'h0;
      operand_addr <= 24'h000000;
    end else begin
      prdata       <= (psel && penable && !pready && !pwrite) ? next_prdata : 32'h00000000;
      pslverr      <= psel && penable && !pready && !mapped;
      active_bank  <= {rs1, rs0};
      operand_addr <= next_agout.addr;
    end
  end

endmodule : psaddr_core

// File: psaddr_regs.svh
`ifndef PSADDR_REGS_SVH
`define PSADDR_REGS_SVH

// APB register byte addresses
`define PSADDR_OFF_PSW        12'h000
`define PSADDR_OFF_EXTENDED_STATUS_REGISTER       12'h004
`define PSADDR_OFF_ACC        12'h008
`define PSADDR_OFF_OPCTL      12'h00C
`define PSADDR_OFF_OPA        12'h010
`define PSADDR_OFF_OPB        12'h014
`define PSADDR_OFF_RESULT     12'h018
`define PSADDR_OFF_AGCTL      12'h01C
`define PSADDR_OFF_AGBASE     12'h020
`define PSADDR_OFF_AGOFS      12'h024
`define PSADDR_OFF_AGOUT      12'h028
`define PSADDR_OFF_DPX        12'h02C
`define PSADDR_OFF_REGIDX     12'h030
`define PSADDR_OFF_REGDATA    12'h034
`define PSADDR_OFF_RAMADDR    12'h038
`define PSADDR_OFF_RAMDATA    12'h03C

// Primary status bit positions
`define PSADDR_PSW_CY   7
`define PSADDR_PSW_AC   6
`define PSADDR_PSW_F0   5
`define PSADDR_PSW_RS1  4
`define PSADDR_PSW_RS0  3
`define PSADDR_PSW_OV   2
`define PSADDR_PSW_UD   1
`define PSADDR_PSW_P    0
// Extended status bit positions
`define PSADDR_EXTENDED_STATUS_REGISTER_CY  7
`define PSADDR_EXTENDED_STATUS_REGISTER_AC  6
`define PSADDR_EXTENDED_STATUS_REGISTER_N   5
`define PSADDR_EXTENDED_STATUS_REGISTER_RS1 4
`define PSADDR_EXTENDED_STATUS_REGISTER_RS0 3
`define PSADDR_EXTENDED_STATUS_REGISTER_OV  2
`define PSADDR_EXTENDED_STATUS_REGISTER_Z   1

// Reset value, fill words, address limits and register indices
`define PSADDR_EXTERNAL_REGION_SELECT_RST 8'h01
`define PSADDR_WORD_ZERO 16'h0000
`define PSADDR_WORD_ONES 16'hFFFF
`define PSADDR_LOW_RAM_TOP 24'h00007F
`define PSADDR_SFR_TOP     24'h0001FF
`define PSADDR_IDX_DPX  5'h0E
`define PSADDR_IDX_SPX  5'h0F

`endif

// File: psaddr_pkg.sv
package psaddr_pkg;

  typedef enum logic [3:0] {
    PSADDR_OP_ADD, PSADDR_OP_SUB, PSADDR_OP_CMP, PSADDR_OP_INC, PSADDR_OP_DEC,
    PSADDR_OP_MUL, PSADDR_OP_DIV, PSADDR_OP_AND, PSADDR_OP_OR, PSADDR_OP_XOR,
    PSADDR_OP_SLL, PSADDR_OP_SRL, PSADDR_OP_SRA, PSADDR_OP_MOVH, PSADDR_OP_MOVL,
    PSADDR_OP_IMM
  } psaddr_op_t;

  typedef enum logic [1:0] {
    PSADDR_SZ_BYTE, PSADDR_SZ_WORD, PSADDR_SZ_DWORD, PSADDR_SZ_RSVD
  } psaddr_size_t;

  typedef enum logic [2:0] {
    PSADDR_AM_DIR8, PSADDR_AM_DIR16, PSADDR_AM_IND_W, PSADDR_AM_IND_D,
    PSADDR_AM_IND_RI, PSADDR_AM_DISP_W, PSADDR_AM_DISP_D, PSADDR_AM_EXT
  } psaddr_amode_t;

  typedef struct packed {
    logic [1:0]   step;
    logic         fill_ones;
    psaddr_size_t size;
    psaddr_op_t   op;
  } psaddr_opctl_t;

  typedef struct packed {
    logic          sfr;
    logic          word_access;
    psaddr_amode_t mode;
  } psaddr_agctl_t;

  typedef struct packed {
    logic        fault;
    logic        sfr;
    logic [23:0] addr;
  } psaddr_agout_t;

endpackage : psaddr_pkg

// File: psaddr_ram.sv
`timescale 1ns/1ps
// Register-file backing store, 32 bytes covering all four banks
module psaddr_ram (
  // Clock
  input  wire logic       pclk,
  // Write port
  input  wire logic       we,
  input  wire logic [4:0] waddr,
  input  wire logic [7:0] wdata,
  // Registered read port
  input  wire logic [4:0] raddr,
  output logic      [7:0] rdata
);
  logic [7:0] mem [32];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk) begin
    rdata <= mem[raddr];
  end
endmodule : psaddr_ram

// File: psaddr_core_chk.sv
`timescale 1ns/1ps
`include "psaddr_regs.svh"
// ====================
// Port checker
module psaddr_chk (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  // Observation
  input  wire logic [1:0]  active_bank,
  input  wire logic [23:0] operand_addr
);
  logic       acc_w;
  logic       bank_w;
  logic       ag_w;
  logic       mapped;
  logic [1:0] bank_q;

  assign acc_w  = psel && penable && pready && pwrite;
  assign bank_w = acc_w && (paddr == `PSADDR_OFF_PSW || paddr == `PSADDR_OFF_EXTENDED_STATUS_REGISTER);
  assign ag_w   = acc_w && (paddr == `PSADDR_OFF_AGCTL || paddr == `PSADDR_OFF_AGBASE ||
                            paddr == `PSADDR_OFF_AGOFS || paddr == `PSADDR_OFF_DPX);
  assign mapped = paddr[1:0] == 2'h0 && paddr <= `PSADDR_OFF_RAMDATA;

  // Bank bits last written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bank_q <= 2'h0;
    else if (bank_w) bank_q <= pwdata[4:3];
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_after_setup: assert property (psel && !penable |=> ##1 pready)
    else $error("pready missing after setup");
  a_ready_in_access: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready outside access phase");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_refused: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  a_bank_follows: assert property (
    bank_w |=> ##[0:1] active_bank == bank_q)
    else $error("bank select not followed");
  a_bank_hold: assert property (
    $changed(active_bank) |-> $past(bank_w) || $past(bank_w, 2))
    else $error("bank changed without write");
  a_addr_hold: assert property (
    $changed(operand_addr) |-> $past(ag_w) || $past(ag_w, 2))
    else $error("operand address changed without cause");
endmodule : psaddr_chk

bind psaddr_core psaddr_chk psaddr_chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .prdata, .active_bank, .operand_addr);

// File: psaddr_core_tb_top.sv
`timescale 1ns/1ps
`include "psaddr_regs.svh"
module psaddr_core_tb_top import psaddr_pkg::*; ;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic [1:0]  active_bank;
  logic [23:0] operand_addr;
  logic [31:0] q;
  logic        e;
  int          mismatches;
  int          total_checks;

  psaddr_core psaddr_core_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .prdata, .active_bank, .operand_addr);

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ====================
  // Helpers
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, x);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      mismatches++;
      test_done;
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask : rd

  task automatic op(input psaddr_op_t o, input psaddr_size_t z, input logic [1:0] st,
                    input logic f, input logic [31:0] a, input logic [31:0] b,
                    input logic [7:0] p0, input logic [31:0] xr, input logic [7:0] m,
                    input logic [7:0] xp);
    wr(`PSADDR_OFF_PSW, {24'h0, p0});
    wr(`PSADDR_OFF_OPA, a);
    wr(`PSADDR_OFF_OPB, b);
    wr(`PSADDR_OFF_OPCTL, {23'h0, st, f, z, o});
    rd(`PSADDR_OFF_RESULT, xr);
    apb(1'b0, `PSADDR_OFF_PSW, 32'h0);
    chk({24'h0, q[7:0] & m}, {24'h0, xp});
  endtask : op

  task automatic ag(input psaddr_amode_t md, input logic w, input logic s,
                    input logic [31:0] b, input logic [31:0] o, input logic [31:0] x);
    wr(`PSADDR_OFF_AGCTL, {27'h0, s, w, md});
    wr(`PSADDR_OFF_AGBASE, b);
    wr(`PSADDR_OFF_AGOFS, o);
    rd(`PSADDR_OFF_AGOUT, x);
    chk({8'h0, operand_addr}, {8'h0, x[23:0]});
  endtask : ag

  // ====================
  // Scenarios
  task automatic t_status;
    rd(`PSADDR_OFF_DPX, 32'h1);
    wr(`PSADDR_OFF_ACC, 32'h7);
    wr(`PSADDR_OFF_PSW, 32'h0);
    rd(`PSADDR_OFF_PSW, 32'h1);
    wr(`PSADDR_OFF_ACC, 32'h6);
    wr(`PSADDR_OFF_PSW, 32'hFF);
    rd(`PSADDR_OFF_PSW, 32'hFE);
    rd(`PSADDR_OFF_EXTENDED_STATUS_REGISTER, 32'hDC);
    chk({30'h0, active_bank}, 32'h3);
    wr(`PSADDR_OFF_EXTENDED_STATUS_REGISTER, 32'h22);
    rd(`PSADDR_OFF_PSW, 32'h22);
    chk({30'h0, active_bank}, 32'h0);
  endtask : t_status

  task automatic t_banks;
    for (int b = 0; b < 4; b++) begin
      wr(`PSADDR_OFF_PSW, b << 3);
      wr(`PSADDR_OFF_REGIDX, 32'h2);
      wr(`PSADDR_OFF_REGDATA, 32'hA0 + b);
    end
    for (int b = 0; b < 4; b++) begin
      wr(`PSADDR_OFF_RAMADDR, b * 8 + 2);
      rd(`PSADDR_OFF_RAMDATA, 32'hA0 + b);
    end
    wr(`PSADDR_OFF_PSW, 32'h08);
    rd(`PSADDR_OFF_REGDATA, 32'hA1);
  endtask : t_banks

  task automatic t_ops;
    op(PSADDR_OP_ADD, PSADDR_SZ_BYTE, 0, 0, 'hFF, 'h1, 'h22, 'h0, 'hFF, 'hE2);
    op(PSADDR_OP_ADD, PSADDR_SZ_WORD, 0, 0, 'hF, 'h1, 'h62, 'h10, 'hFF, 'h62);
    op(PSADDR_OP_MUL, PSADDR_SZ_BYTE, 0, 0, 'hF, 'h2, 'h80, 'h1E, 'h84, 'h0);
    op(PSADDR_OP_DIV, PSADDR_SZ_BYTE, 0, 0, 'h7, 'h2, 'h80, 'h103, 'h84, 'h0);
    op(PSADDR_OP_DIV, PSADDR_SZ_BYTE, 0, 0, 'h7, 'h0, 'h80, 'h103, 'h84, 'h4);
    op(PSADDR_OP_SLL, PSADDR_SZ_BYTE, 0, 0, 'h81, 'h0, 'h0, 'h2, 'h80, 'h80);
    op(PSADDR_OP_SRL, PSADDR_SZ_BYTE, 0, 0, 'h1, 'h0, 'h0, 'h0, 'h80, 'h80);
    op(PSADDR_OP_SRA, PSADDR_SZ_BYTE, 0, 0, 'h80, 'h0, 'h80, 'hC0, 'h80, 'h0);
    for (int s = 0; s < 4; s++)
      op(PSADDR_OP_INC, PSADDR_SZ_BYTE, s[1:0], 0, 'h10, 'h0, 'h0,
         32'h10 + (s == 0 ? 1 : s == 1 ? 2 : 4), 'h0, 'h0);
    op(PSADDR_OP_DEC, PSADDR_SZ_DWORD, 2, 0, 'h100, 'h0, 'h0, 'hFC, 'h0, 'h0);
    for (int f = 0; f < 2; f++) begin
      op(PSADDR_OP_IMM, PSADDR_SZ_DWORD, 0, f[0], 'h8001, 'h8001, 'h0,
         {{16{f[0]}}, 16'h8001}, 'h0, 'h0);
      op(PSADDR_OP_MOVL, PSADDR_SZ_DWORD, 0, f[0], 'h12345678, 'h8001, 'h0,
         {{16{f[0]}}, 16'h8001}, 'h0, 'h0);
    end
    op(PSADDR_OP_MOVH, PSADDR_SZ_DWORD, 0, 0, 'h12345678, 'hABCD, 'h0,
       'hABCD5678, 'h0, 'h0);
  endtask : t_ops

  task automatic t_addr;
    ag(PSADDR_AM_DIR8, 1, 0, 'h0, 'h7E, 'h7E);
    ag(PSADDR_AM_DIR8, 0, 1, 'h0, 'h1FF, 'h010001FF);
    ag(PSADDR_AM_DIR8, 1, 1, 'h0, 'h80, 'h03000080);
    ag(PSADDR_AM_DIR16, 1, 0, 'h0, 'hFFFE, 'hFFFE);
    ag(PSADDR_AM_IND_W, 0, 0, 'hFFABCD, 'h0, 'hABCD);
    ag(PSADDR_AM_IND_D, 0, 0, 'h123456, 'h0, 'h123456);
    ag(PSADDR_AM_IND_RI, 0, 0, 'hC5, 'h0, 'hC5);
    ag(PSADDR_AM_DISP_W, 0, 0, 'hF000, 'h2005, 'h1005);
    ag(PSADDR_AM_DISP_W, 0, 0, 'h2005, 'hF000, 'h1005);
    ag(PSADDR_AM_DISP_D, 0, 0, 'h12000, 'hF000, 'h11000);
    ag(PSADDR_AM_EXT, 0, 0, 'h1234, 'h0, 'h11234);
    wr(`PSADDR_OFF_DPX, 32'h7);
    ag(PSADDR_AM_EXT, 0, 0, 'h1234, 'h0, 'h71234);
  endtask : t_addr

  task automatic t_refuse;
    apb(1'b0, 12'h040, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    apb(1'b1, 12'h0FC, 32'h5A);
    chk({31'h0, e}, 32'h1);
  endtask : t_refuse

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_status;
    t_banks;
    t_ops;
    t_addr;
    t_refuse;
    test_done;
  end

  // Hang guard
  initial begin
    #100000;
    mismatches++;
    test_done;
  end
endmodule : psaddr_core_tb_top
